// *** logic/tae_top.sv ***
/*
 File: thermal alarm logic - limit registers, conversion pacing, window and critical
 comparison, open-drain alarm output and temperature read snapshot.
 Assumes: a bus engine on clk_sys_i presents register accesses as one-cycle strobes; the
 converter toggles conv_toggle_i once per finished conversion and holds conv_temp_i steady
 from before the toggle until the next start request.
*/
// How it works
// - Upper limit at 02h, lower at 03h
// - Critical limit at 04h, with hysteresis
// - Hysteresis delays leaving above or critical, lowers lower limit
// - Enabled output triggers on window crossings
// - Critical asserts output until temperature drops
// - Critical ignores clear bit and alert response
// - Comparator asserts while outside the window
// - Critical-only mode follows only critical limit
// - Comparator output unaffected by register access
// - Interrupt asserts on crossing, clear-bit deasserts
// - Interrupt reasserts at critical, drops leaving it
// - Critical band forces comparator, ignores mode bit
// - Reading carries critical, above, below flags
// - Limit write skips one conversion before comparing
// - Non-critical interrupt clears by bit or alert
// - Conversion started every 125 ms
// - Read returns newest completed conversion
// - Read data frozen for whole transfer
// - Config bits select mode, bands, hysteresis
// - Four hysteresis amounts 0/1.5/3/6 degrees
// - Config bit 1 selects output polarity
// - Bit 4 shows alarm, bit 5 clears
`include "tae_map.svh"

module tae_top #(
  parameter int unsigned CONV_CYCLES = `TAE_CONV_PERIOD_MS * `TAE_CLK_KHZ
) (
  input  wire logic               clk_sys_i,
  input  wire logic               rst_n_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_start_i,
  input  wire logic [7:0]         reg_ptr_i,
  input  wire logic [15:0]        reg_wdata_i,
  input  wire logic               alert_resp_i,
  input  wire logic               conv_toggle_i,
  input  wire tae_pkg::tae_temp_t conv_temp_i,
  output logic [15:0]             reg_rdata_o,
  output logic                    conv_start_o,
  output logic                    alarm_o,
  output logic                    alarm_oe_n_o
);

  logic                 rst_meta_r;
  logic                 rst_n_r;
  logic                 conv_sync;
  logic                 conv_seen_r;
  logic                 conv_land;
  logic [2:0]           conv_warm_r;
  logic [23:0]          conv_cnt_r;
  tae_pkg::tae_temp_t   upper_r;
  tae_pkg::tae_temp_t   lower_r;
  tae_pkg::tae_temp_t   crit_r;
  tae_pkg::tae_temp_t   temp_r;
  logic                 mode_int_r;
  logic                 pol_high_r;
  logic                 crit_only_r;
  logic                 enable_r;
  logic [1:0]           hyst_r;
  logic                 hold_r;
  logic                 crit_flag_r;
  logic                 above_r;
  logic                 below_r;
  logic                 crit_nxt;
  logic                 above_nxt;
  logic                 below_nxt;
  logic                 flags_upd;
  logic                 crossing;
  logic                 clear_req;
  logic                 wr_cfg;
  logic                 wr_limit;
  tae_pkg::tae_alarm_e  alarm_r;
  tae_pkg::tae_alarm_e  alarm_nxt;
  logic                 asserted;
  logic [15:0]          temp_word;
  logic [15:0]          cfg_word;
  logic [15:0]          rd_sel;

  // Reset released through two flops
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  tae_sync u_conv_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_r),
    .async_i   (conv_toggle_i),
    .sync_o    (conv_sync)
  );

  // Detector stays blind until the synchroniser holds the pin level,
  // so a toggle left high across a reset is not taken for a conversion
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      conv_seen_r <= 1'b0;
      conv_warm_r <= `TAE_RST_WARM;
    end else begin
      conv_seen_r <= conv_sync;
      conv_warm_r <= {conv_warm_r[1:0], 1'b1};
    end
  end

  // Any toggle edge marks a finished conversion
  assign conv_land = conv_warm_r[2] && (conv_sync ^ conv_seen_r);

  // Conversion pacing, one start per period
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      conv_cnt_r   <= `TAE_CNT_ZERO;
      conv_start_o <= 1'b0;
    end else if (conv_cnt_r == 24'(CONV_CYCLES - 1)) begin
      conv_cnt_r   <= `TAE_CNT_ZERO;
      conv_start_o <= 1'b1;
    end else begin
      conv_cnt_r   <= conv_cnt_r + 24'h000001;
      conv_start_o <= 1'b0;
    end
  end

  assign wr_cfg   = reg_wr_i && (reg_ptr_i == `TAE_OFS_CONFIG);
  assign wr_limit = reg_wr_i && ((reg_ptr_i == `TAE_OFS_UPPER) || (reg_ptr_i == `TAE_OFS_LOWER)
                                 || (reg_ptr_i == `TAE_OFS_CRIT));

  // Limit registers
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      upper_r <= `TAE_RST_TEMP;
      lower_r <= `TAE_RST_TEMP;
      crit_r  <= `TAE_RST_TEMP;
    end else if (reg_wr_i) begin
      if (reg_ptr_i == `TAE_OFS_UPPER) begin
        upper_r <= reg_wdata_i[12:0];
      end else if (reg_ptr_i == `TAE_OFS_LOWER) begin
        lower_r <= reg_wdata_i[12:0];
      end else if (reg_ptr_i == `TAE_OFS_CRIT) begin
        crit_r  <= reg_wdata_i[12:0];
      end
    end
  end

  // Configuration; mode and band bits are frozen while the output stays enabled
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mode_int_r  <= 1'b0;
      pol_high_r  <= 1'b0;
      crit_only_r <= 1'b0;
      enable_r    <= 1'b0;
      hyst_r      <= `TAE_RST_HYST;
    end else if (wr_cfg) begin
      if (!(enable_r && reg_wdata_i[`TAE_CFG_ENABLE])) begin
        mode_int_r  <= reg_wdata_i[`TAE_CFG_MODE];
        crit_only_r <= reg_wdata_i[`TAE_CFG_CRIT_ONLY];
      end
      pol_high_r <= reg_wdata_i[`TAE_CFG_POL];
      enable_r   <= reg_wdata_i[`TAE_CFG_ENABLE];
      hyst_r     <= reg_wdata_i[`TAE_CFG_HYST_HI:`TAE_CFG_HYST_LO];
    end
  end

  // New limits wait out one conversion; a write beside a landing keeps the hold
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      hold_r <= 1'b0;
    end else if (wr_limit) begin
      hold_r <= 1'b1;
    end else if (conv_land) begin
      hold_r <= 1'b0;
    end
  end

  assign flags_upd = conv_land && !hold_r;

  tae_compare u_compare (
    .temp_i      (conv_temp_i),
    .upper_i     (upper_r),
    .lower_i     (lower_r),
    .crit_i      (crit_r),
    .hyst_sel_i  (hyst_r),
    .above_i     (above_r),
    .crit_i_flag (crit_flag_r),
    .crit_o      (crit_nxt),
    .above_o     (above_nxt),
    .below_o     (below_nxt)
  );

  // Latest temperature refreshed per conversion; its flags skip the one held after a limit write
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      temp_r      <= `TAE_RST_TEMP;
      crit_flag_r <= 1'b0;
      above_r     <= 1'b0;
      below_r     <= 1'b0;
    end else begin
      if (conv_land) begin
        temp_r <= conv_temp_i;
      end
      if (flags_upd) begin
        crit_flag_r <= crit_nxt;
        above_r     <= above_nxt;
        below_r     <= below_nxt;
      end
    end
  end

  assign crossing  = flags_upd && ((above_nxt != above_r) || (below_nxt != below_r));
  assign clear_req = (wr_cfg && reg_wdata_i[`TAE_CFG_CLEAR]) || alert_resp_i;

  // Output state; a crossing outranks a clear in the same cycle
  always_comb begin
    alarm_nxt = alarm_r;
    if (!enable_r) begin
      alarm_nxt = tae_pkg::TAE_ALM_OFF;
    end else if (crit_flag_r) begin
      alarm_nxt = tae_pkg::TAE_ALM_CRIT;
    end else if (crit_only_r) begin
      alarm_nxt = tae_pkg::TAE_ALM_OFF;
    end else if (!mode_int_r) begin
      alarm_nxt = (above_r || below_r) ? tae_pkg::TAE_ALM_ON : tae_pkg::TAE_ALM_OFF;
    end else begin
      case (alarm_r)
        tae_pkg::TAE_ALM_CRIT: begin
          alarm_nxt = tae_pkg::TAE_ALM_OFF;
        end
        tae_pkg::TAE_ALM_ON: begin
          if (crossing) begin
            alarm_nxt = tae_pkg::TAE_ALM_ON;
          end else if (clear_req) begin
            alarm_nxt = tae_pkg::TAE_ALM_OFF;
          end
        end
        default: begin
          if (crossing) begin
            alarm_nxt = tae_pkg::TAE_ALM_ON;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      alarm_r <= tae_pkg::TAE_ALM_OFF;
    end else begin
      alarm_r <= alarm_nxt;
    end
  end

  assign asserted = (alarm_r != tae_pkg::TAE_ALM_OFF);

  // Open-drain pin: data is always low, only the enable moves
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      alarm_o      <= 1'b0;
      alarm_oe_n_o <= 1'b1;
    end else begin
      alarm_o      <= 1'b0;
      alarm_oe_n_o <= !(enable_r && (asserted != pol_high_r));
    end
  end

  // A conversion landing with the read start is taken along with its flags
  always_comb begin
    temp_word = {crit_flag_r, above_r, below_r, temp_r};
    if (conv_land) begin
      temp_word[12:0] = conv_temp_i;
    end
    if (flags_upd) begin
      temp_word[`TAE_TMP_CRIT]  = crit_nxt;
      temp_word[`TAE_TMP_ABOVE] = above_nxt;
      temp_word[`TAE_TMP_BELOW] = below_nxt;
    end
    cfg_word                          = `TAE_RST_WORD;
    cfg_word[`TAE_CFG_MODE]           = mode_int_r;
    cfg_word[`TAE_CFG_POL]            = pol_high_r;
    cfg_word[`TAE_CFG_CRIT_ONLY]      = crit_only_r;
    cfg_word[`TAE_CFG_ENABLE]         = enable_r;
    cfg_word[`TAE_CFG_STATUS]         = asserted;
    cfg_word[`TAE_CFG_HYST_HI:`TAE_CFG_HYST_LO] = hyst_r;
    if (reg_ptr_i == `TAE_OFS_CONFIG) begin
      rd_sel = cfg_word;
    end else if (reg_ptr_i == `TAE_OFS_UPPER) begin
      rd_sel = {3'h0, upper_r};
    end else if (reg_ptr_i == `TAE_OFS_LOWER) begin
      rd_sel = {3'h0, lower_r};
    end else if (reg_ptr_i == `TAE_OFS_CRIT) begin
      rd_sel = {3'h0, crit_r};
    end else if (reg_ptr_i == `TAE_OFS_TEMP) begin
      rd_sel = temp_word;
    end else begin
      rd_sel = `TAE_RST_WORD;
    end
  end

  // Snapshot at read start; both bytes come from this one word
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      reg_rdata_o <= `TAE_RST_WORD;
    end else if (reg_rd_start_i) begin
      reg_rdata_o <= rd_sel;
    end
  end

endmodule // tae_top

// *** include/tae_map.svh ***
/*
 File: offsets, field positions, reset values and timing figures of the thermal alarm logic.
 Assumes: it is included by its bare name, once per compile unit or behind the guard.
*/
`ifndef TAE_MAP_SVH
`define TAE_MAP_SVH

// Register pointer values
`define TAE_OFS_CONFIG        8'h01
`define TAE_OFS_UPPER         8'h02
`define TAE_OFS_LOWER         8'h03
`define TAE_OFS_CRIT          8'h04
`define TAE_OFS_TEMP          8'h05

// Configuration field positions
`define TAE_CFG_MODE          0
`define TAE_CFG_POL           1
`define TAE_CFG_CRIT_ONLY     2
`define TAE_CFG_ENABLE        3
`define TAE_CFG_STATUS        4
`define TAE_CFG_CLEAR         5
`define TAE_CFG_HYST_LO       9
`define TAE_CFG_HYST_HI       10

// Temperature reading flag positions
`define TAE_TMP_CRIT          15
`define TAE_TMP_ABOVE         14
`define TAE_TMP_BELOW         13

// Reset values
`define TAE_RST_WORD          16'h0000
`define TAE_RST_TEMP          13'h0000
`define TAE_RST_HYST          2'h0
`define TAE_RST_WARM          3'h0

// Hysteresis in 0.0625 degree steps: 0, 1.5, 3 and 6 degrees
`define TAE_HYST_0            14'h0000
`define TAE_HYST_1P5          14'h0018
`define TAE_HYST_3            14'h0030
`define TAE_HYST_6            14'h0060

// Conversion period
`define TAE_CONV_PERIOD_MS    125
`define TAE_CLK_KHZ           100000
`define TAE_CNT_ZERO          24'h000000

`endif

// *** include/tae_pkg.sv ***
/*
 File: types shared by the thermal alarm logic.
 Assumes: compiled before every module of the block.
*/
package tae_pkg;

  typedef logic [12:0] tae_temp_t;

  // Alarm output state, one-hot
  typedef enum logic [2:0] {
    TAE_ALM_OFF  = 3'h1,
    TAE_ALM_ON   = 3'h2,
    TAE_ALM_CRIT = 3'h4
  } tae_alarm_e;

endpackage

// *** logic/tae_sync.sv ***
/*
 File: two-flop level synchroniser.
 Assumes: the input comes from another clock domain; reset is already synchronous-released.
*/
module tae_sync (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  input  wire logic async_i,
  output logic      sync_o
);

  logic meta_r;

  // First flop is read only by the second
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule // tae_sync

// *** logic/tae_compare.sv ***
/*
 File: threshold comparison with hysteresis for one conversion result.
 Assumes: temperatures are 13-bit two's complement in 0.0625 degree steps.
*/
`include "tae_map.svh"

module tae_compare (
  input  wire tae_pkg::tae_temp_t temp_i,
  input  wire tae_pkg::tae_temp_t upper_i,
  input  wire tae_pkg::tae_temp_t lower_i,
  input  wire tae_pkg::tae_temp_t crit_i,
  input  wire logic [1:0]         hyst_sel_i,
  input  wire logic               above_i,
  input  wire logic               crit_i_flag,
  output logic                    crit_o,
  output logic                    above_o,
  output logic                    below_o
);

  logic signed [13:0] t_s;
  logic signed [13:0] u_s;
  logic signed [13:0] l_s;
  logic signed [13:0] c_s;
  logic signed [13:0] h_s;

  // One extra bit keeps limit minus hysteresis from wrapping
  always_comb begin
    t_s = $signed({temp_i[12], temp_i});
    u_s = $signed({upper_i[12], upper_i});
    l_s = $signed({lower_i[12], lower_i});
    c_s = $signed({crit_i[12], crit_i});
    case (hyst_sel_i)
      2'h0:    h_s = $signed(`TAE_HYST_0);
      2'h1:    h_s = $signed(`TAE_HYST_1P5);
      2'h2:    h_s = $signed(`TAE_HYST_3);
      default: h_s = $signed(`TAE_HYST_6);
    endcase
    crit_o  = crit_i_flag ? (t_s >= c_s - h_s) : (t_s >= c_s);
    above_o = above_i ? (t_s > u_s - h_s) : (t_s > u_s);
    below_o = (t_s < l_s - h_s);
  end

endmodule // tae_compare

// *** testbench/tae_conv_model.sv ***
/* Converter model: finishes one conversion per call with a toggle edge.
   Assumes: the block syncs the toggle; the result is held until the next call. */
module tae_conv_model (
  output logic               conv_toggle_o,
  output tae_pkg::tae_temp_t conv_temp_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic clk_link;

  initial begin
    clk_link = 1'h0;
    conv_toggle_o = 1'h0;
    conv_temp_o = 13'h0000;
  end

  // Link clock runs only inside a conversion; result settles well before the edge
  task automatic convert(input tae_pkg::tae_temp_t t, input int n);
    conv_temp_o <= t;
    repeat (n) begin
      #40 clk_link = 1'h1;
      #40 clk_link = 1'h0;
    end
    conv_toggle_o <= ~conv_toggle_o;
    #800;
  endtask
endmodule // tae_conv_model

// *** testbench/tae_checker.sv ***
/* Checker: port assertions of the thermal alarm logic.
   Assumes: bound into tae_top; one clock domain. */
`include "tae_map.svh"

module tae_checker #(
  parameter int unsigned CONV_CYCLES = 200
) (
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_start_i,
  input wire logic [7:0]  reg_ptr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic        alert_resp_i,
  input wire logic        conv_toggle_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic        conv_start_o,
  input wire logic        alarm_o,
  input wire logic        alarm_oe_n_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  int unsigned gap_r;
  logic        seen_r;
  logic        en_r;
  logic        tog_r;
  logic [3:0]  quiet_r;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gap_r <= 32'h0;
      seen_r <= 1'h0;
      en_r <= 1'h0;
      tog_r <= 1'h0;
      quiet_r <= 4'h0;
    end else begin
      gap_r <= conv_start_o ? 32'h0 : gap_r + 32'h1;
      seen_r <= seen_r | conv_start_o;
      tog_r <= conv_toggle_i;
      if (reg_wr_i && reg_ptr_i == `TAE_OFS_CONFIG) begin
        en_r <= reg_wdata_i[`TAE_CFG_ENABLE];
      end
      // Any cause that may move the pin restarts the count
      if (reg_wr_i || alert_resp_i || tog_r != conv_toggle_i) begin
        quiet_r <= 4'h0;
      end else if (quiet_r != 4'hF) begin
        quiet_r <= quiet_r + 4'h1;
      end
    end
  end

  sequence s_start;
    conv_start_o;
  endsequence
  sequence s_read(logic [7:0] p);
    reg_rd_start_i && reg_ptr_i == p;
  endsequence

  property p_start_width;
    s_start |=> !conv_start_o [*8];
  endproperty
  property p_start_period;
    s_start ##0 seen_r |-> gap_r == CONV_CYCLES - 1;
  endproperty
  property p_read_hold;
    !reg_rd_start_i |=> $stable(reg_rdata_o);
  endproperty
  property p_cfg_zero;
    s_read(`TAE_OFS_CONFIG) |=> reg_rdata_o[15:11] == 5'h00 && reg_rdata_o[8:5] == 4'h0;
  endproperty
  property p_limit_top;
    s_read(`TAE_OFS_UPPER) or s_read(`TAE_OFS_LOWER) or s_read(`TAE_OFS_CRIT) |=> reg_rdata_o[15:13] == 3'h0;
  endproperty
  property p_drain_only;
    alarm_o == 1'h0;
  endproperty
  property p_off_released;
    !en_r && !$past(en_r) && !$past(en_r, 2) |-> alarm_oe_n_o;
  endproperty
  property p_pin_quiet;
    quiet_r >= 4'hC |-> $stable(alarm_oe_n_o);
  endproperty

  a_start_width: assert property (p_start_width) else $error("start pulse too wide");
  a_start_period: assert property (p_start_period) else $error("start period wrong");
  a_read_hold: assert property (p_read_hold) else $error("read data moved");
  a_cfg_zero: assert property (p_cfg_zero) else $error("config spare bits set");
  a_limit_top: assert property (p_limit_top) else $error("limit top bits set");
  a_drain_only: assert property (p_drain_only) else $error("pin driven high");
  a_off_released: assert property (p_off_released) else $error("disabled pin pulled");
  a_pin_quiet: assert property (p_pin_quiet) else $error("pin moved without cause");
endmodule // tae_checker

bind tae_top tae_checker #(.CONV_CYCLES(CONV_CYCLES)) tae_checker_i (
  .clk_sys_i, .rst_n_i, .reg_wr_i, .reg_rd_start_i, .reg_ptr_i, .reg_wdata_i,
  .alert_resp_i, .conv_toggle_i, .reg_rdata_o, .conv_start_o, .alarm_o, .alarm_oe_n_o
);

// *** testbench/thermal_alarm_event_logic_tb_top.sv ***
/* Testbench: limits, modes, flags and readout of the thermal alarm logic.
   Assumes: converter model on the link side; pull-up on the alarm pin. */
`include "tae_map.svh"

module thermal_alarm_event_logic_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {
    logic [15:0]        cfg;
    tae_pkg::tae_temp_t t;
    logic [2:0]         f;
    logic               pin;
  } tae_row_s;

  logic               clk_sys_i = 1'h0;
  logic               rst_n_i = 1'h0;
  logic               reg_wr_i = 1'h0;
  logic               reg_rd_start_i = 1'h0;
  logic               alert_resp_i = 1'h0;
  logic [7:0]         reg_ptr_i = 8'h00;
  logic [15:0]        reg_wdata_i = 16'h0000;
  logic [15:0]        reg_rdata_o;
  logic [15:0]        v;
  logic               conv_toggle_i;
  logic               conv_start_o;
  logic               alarm_o;
  logic               alarm_oe_n_o;
  tae_pkg::tae_temp_t conv_temp_i;
  int                 bad_count = 0;
  int                 n_tests = 0;
  // Pull-up wins while released
  wire                pin = alarm_oe_n_o ? 1'h1 : alarm_o;

  tae_pkg::tae_temp_t hy [4] = '{13'h0000, 13'h0018, 13'h0030, 13'h0060};
  tae_row_s rows [8] = '{
    '{16'h0008, 13'h0400, 3'h0, 1'h1},
    '{16'h0008, 13'h0560, 3'h2, 1'h0},
    '{16'h0008, 13'h1E00, 3'h1, 1'h0},
    '{16'h0008, 13'h0600, 3'h6, 1'h0},
    '{16'h000A, 13'h0560, 3'h2, 1'h1},
    '{16'h000C, 13'h0560, 3'h2, 1'h1},
    '{16'h000C, 13'h05F0, 3'h6, 1'h0},
    '{16'h0000, 13'h0600, 3'h6, 1'h1}
  };

  tae_top #(.CONV_CYCLES(200)) tae_top_i (
    .clk_sys_i, .rst_n_i, .reg_wr_i, .reg_rd_start_i, .reg_ptr_i, .reg_wdata_i,
    .alert_resp_i, .conv_toggle_i, .conv_temp_i, .reg_rdata_o, .conv_start_o,
    .alarm_o, .alarm_oe_n_o
  );
  tae_conv_model tae_conv_model_i (
    .conv_toggle_o(conv_toggle_i),
    .conv_temp_o  (conv_temp_i)
  );

  always #5 clk_sys_i = ~clk_sys_i;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask

  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'h1;
    reg_ptr_i <= p;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'h0;
    repeat (3) @(posedge clk_sys_i);
  endtask

  task automatic rd(input logic [7:0] p);
    @(posedge clk_sys_i);
    reg_rd_start_i <= 1'h1;
    reg_ptr_i <= p;
    @(posedge clk_sys_i);
    reg_rd_start_i <= 1'h0;
    @(negedge clk_sys_i);
    v = reg_rdata_o;
  endtask

  task automatic alert();
    @(posedge clk_sys_i);
    alert_resp_i <= 1'h1;
    @(posedge clk_sys_i);
    alert_resp_i <= 1'h0;
    repeat (3) @(posedge clk_sys_i);
  endtask

  // Enable must drop first, or mode bits stay locked
  task automatic cfg(input logic [15:0] d);
    wr(`TAE_OFS_CONFIG, 16'h0000);
    wr(`TAE_OFS_CONFIG, d);
  endtask

  task automatic conv(input tae_pkg::tae_temp_t t);
    tae_conv_model_i.convert(t, 2);
  endtask

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #900000;
    bad_count++;
    final_report();
  end

  initial begin
    repeat (8) @(posedge clk_sys_i);
    rst_n_i <= 1'h1;
    repeat (3) @(posedge clk_sys_i);
    wr(`TAE_OFS_UPPER, 16'h0550);
    wr(`TAE_OFS_LOWER, 16'h1F40);
    wr(`TAE_OFS_CRIT, 16'h05F0);
    conv(13'h0400);
    foreach (rows[i]) begin
      cfg(rows[i].cfg);
      conv(rows[i].t);
      rd(`TAE_OFS_TEMP);
      chk(v, {rows[i].f, rows[i].t});
      chk(16'(pin), 16'(rows[i].pin));
    end
    for (int h = 0; h < 4; h++) begin
      cfg({5'h00, 2'(h), 9'h008});
      conv(13'h0551);
      conv(13'h0551 - hy[h]);
      rd(`TAE_OFS_TEMP);
      chk(16'(v[14]), 16'h0001);
      conv(13'h0550 - hy[h]);
      rd(`TAE_OFS_TEMP);
      chk(16'(v[14]), 16'h0000);
    end
    cfg(16'h0009);
    conv(13'h0400);
    conv(13'h0560);
    chk(16'(pin), 16'h0000);
    wr(`TAE_OFS_CONFIG, 16'h0029);
    chk(16'(pin), 16'h0001);
    conv(13'h0600);
    wr(`TAE_OFS_CONFIG, 16'h0029);
    alert();
    chk(16'(pin), 16'h0000);
    rd(`TAE_OFS_CONFIG);
    chk(v, 16'h0019);
    conv(13'h0560);
    chk(16'(pin), 16'h0001);
    conv(13'h0400);
    chk(16'(pin), 16'h0000);
    alert();
    chk(16'(pin), 16'h0001);
    cfg(16'h0008);
    conv(13'h0560);
    wr(`TAE_OFS_CONFIG, 16'h0028);
    alert();
    chk(16'(pin), 16'h0000);
    wr(`TAE_OFS_UPPER, 16'hE5A0);
    rd(`TAE_OFS_UPPER);
    chk(v, 16'h05A0);
    conv(13'h0560);
    chk(16'(pin), 16'h0000);
    conv(13'h0561);
    chk(16'(pin), 16'h0001);
    rd(`TAE_OFS_TEMP);
    conv(13'h0562);
    chk(reg_rdata_o, 16'h0561);
    wr(`TAE_OFS_TEMP, 16'h1234);
    rd(`TAE_OFS_TEMP);
    chk(v, 16'h0562);
    rd(8'h07);
    chk(v, 16'h0000);
    conv(13'h0600);
    rst_n_i <= 1'h0;
    repeat (2) @(posedge clk_sys_i);
    chk(16'(pin), 16'h0001);
    rst_n_i <= 1'h1;
    repeat (3) @(posedge clk_sys_i);
    rd(`TAE_OFS_CRIT);
    chk(v, 16'h0000);
    // Toggle is left high here; no conversion may be seen after reset
    rd(`TAE_OFS_TEMP);
    chk(v, 16'h0000);
    final_report();
  end
endmodule // thermal_alarm_event_logic_tb_top
